//--- hdl/psb_burst_seq.sv
// Two-bit burst address sequencer, linear or interleaved order
`timescale 1ns/100ps
module psb_burst_seq
   import psb_pkg::*;
(
   input  wire logic [BURST_LO_W-1:0] i_base,
   input  wire logic [BURST_LO_W-1:0] i_beat,
   input  wire logic                  i_interleave,
   output      logic [BURST_LO_W-1:0] o_lo
);

   // ------------------------------------------------------------------
   // Sequence selection
   // ------------------------------------------------------------------
   // Two-bit sum wraps after the fourth beat by itself
   wire logic [BURST_LO_W-1:0] lin_lo = i_base + i_beat;
   wire logic [BURST_LO_W-1:0] ilv_lo = i_base ^ i_beat;

   assign o_lo = i_interleave ? ilv_lo : lin_lo;

endmodule : psb_burst_seq

//--- hdl/psb_pair_buf.sv
// Two-entry fall-through buffer with valid and ready on both sides
`timescale 1ns/100ps
module psb_pair_buf
   import psb_pkg::*;
#(
   parameter int WIDTH = 37
)(
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_in_valid,
   output      logic             o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output      logic             o_out_valid,
   input  wire logic             i_out_ready,
   output      logic [WIDTH-1:0] o_out_data
);

   logic [WIDTH-1:0] ent0_reg;
   logic [WIDTH-1:0] ent1_reg;
   logic [1:0]       cnt_reg;

   // ------------------------------------------------------------------
   // Handshake decode
   // ------------------------------------------------------------------
   // Empty buffer passes the word straight through, so no latency is added
   wire logic empty = (cnt_reg == BUF_CNT_RST);
   wire logic push  = i_in_valid & o_in_ready;
   wire logic pop   = o_out_valid & i_out_ready;

   assign o_in_ready  = (cnt_reg != BUF_CNT_FULL);
   assign o_out_valid = ~empty | i_in_valid;
   assign o_out_data  = empty ? i_in_data : ent0_reg;

   // Storage; head is always ent0
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_reg <= BUF_CNT_RST;
      end else begin
         cnt_reg <= cnt_reg + {1'b0, push & ~(empty & pop)} - {1'b0, pop & ~empty};
      end
   end

   always_ff @(posedge i_clk) begin
      if (empty && push && !pop) begin
         ent0_reg <= i_in_data;
      end else if (cnt_reg == 2'h1 && push && pop) begin
         ent0_reg <= i_in_data;
      end else if (cnt_reg == BUF_CNT_FULL && pop) begin
         ent0_reg <= ent1_reg;
      end
      if (cnt_reg == 2'h1 && push && !pop) begin
         ent1_reg <= i_in_data;
      end
   end

endmodule : psb_pair_buf

//--- hdl/psb_sram_top.sv
// Access and control logic of a synchronous pipelined burst SRAM
`timescale 1ns/100ps

module psb_sram_top
   import psb_pkg::*;
#(
   parameter int ADDR_W = 20,
   parameter int LANES  = 4,
   parameter int LANE_W = 9
)(
   input  wire logic                    I_CORE_CLK,
   input  wire logic                    I_RST_N,
   input  wire logic                    I_CLOCK_QUALIFY_N,
   input  wire logic                    I_SELECT_FIRST_N,
   input  wire logic                    I_SELECT_SECOND,
   input  wire logic                    I_SELECT_THIRD_N,
   input  wire logic                    I_ADVANCE_OR_LOAD,
   input  wire logic                    I_WRITE_N,
   input  wire logic [LANES-1:0]        I_BYTE_LANE_WRITE_N,
   input  wire logic [ADDR_W-1:0]       I_ADDR,
   input  wire logic [LANES*LANE_W-1:0] I_DQ,
   input  wire logic                    I_OUTPUT_EN_N,
   input  wire logic                    I_BURST_ORDER,
   input  wire logic                    I_SLEEP_REQUEST,
   input  wire logic                    I_TEST_CLOCK,
   input  wire logic                    I_TEST_MODE_SELECT,
   output      logic [LANES*LANE_W-1:0] O_DQ,
   output      logic                    O_DQ_OE,
   output      logic                    O_SLEEP_ACTIVE,
   output      logic                    O_TEST_MODE_SAMPLE
);

   localparam int DATA_W = LANES * LANE_W;
   localparam int HI_W   = ADDR_W - BURST_LO_W;

   // ------------------------------------------------------------------
   // Input registers for the synchronous pins
   // ------------------------------------------------------------------
   logic                  qual_n_reg;
   logic                  sel_first_n_reg;
   logic                  sel_second_reg;
   logic                  sel_third_n_reg;
   logic                  adv_reg;
   logic                  write_n_reg;
   logic [LANES-1:0]      lane_n_reg;
   logic [ADDR_W-1:0]     addr_reg;
   logic [DATA_W-1:0]     dq_in_reg;

   // Controls reset to an idle, unqualified cycle
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         qual_n_reg      <= QUAL_N_RST;
         sel_first_n_reg <= 1'b1;
         sel_second_reg  <= 1'b0;
         sel_third_n_reg <= 1'b1;
         adv_reg         <= 1'b0;
         write_n_reg     <= 1'b1;
         lane_n_reg      <= '1;
      end else begin
         qual_n_reg      <= I_CLOCK_QUALIFY_N;
         sel_first_n_reg <= I_SELECT_FIRST_N;
         sel_second_reg  <= I_SELECT_SECOND;
         sel_third_n_reg <= I_SELECT_THIRD_N;
         adv_reg         <= I_ADVANCE_OR_LOAD;
         write_n_reg     <= I_WRITE_N;
         lane_n_reg      <= I_BYTE_LANE_WRITE_N;
      end
   end

   // Address and data paths carry no control meaning, so no reset
   always_ff @(posedge I_CORE_CLK) begin
      addr_reg  <= I_ADDR;
      dq_in_reg <= I_DQ;
   end

   // ------------------------------------------------------------------
   // Synchronisers for the asynchronous pins
   // ------------------------------------------------------------------
   logic oe_n_s1_reg;
   logic oe_n_s2_reg;
   logic sleep_s1_reg;
   logic sleep_s2_reg;
   logic order_s1_reg;
   logic order_s2_reg;
   logic tck_s1_reg;
   logic tck_s2_reg;
   logic tck_s3_reg;
   logic tms_s1_reg;
   logic tms_s2_reg;

   // Second stage feeds logic, plus a third stage for the test clock edge; costs a little output-enable latency
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         oe_n_s1_reg  <= 1'b1;
         oe_n_s2_reg  <= 1'b1;
         sleep_s1_reg <= 1'b0;
         sleep_s2_reg <= 1'b0;
         order_s1_reg <= 1'b1;
         order_s2_reg <= 1'b1;
         tck_s1_reg   <= 1'b0;
         tck_s2_reg   <= 1'b0;
         tck_s3_reg   <= 1'b0;
         tms_s1_reg   <= 1'b1;
         tms_s2_reg   <= 1'b1;
      end else begin
         oe_n_s1_reg  <= I_OUTPUT_EN_N;
         oe_n_s2_reg  <= oe_n_s1_reg;
         sleep_s1_reg <= I_SLEEP_REQUEST;
         sleep_s2_reg <= sleep_s1_reg;
         order_s1_reg <= I_BURST_ORDER;
         order_s2_reg <= order_s1_reg;
         tck_s1_reg   <= I_TEST_CLOCK;
         tck_s2_reg   <= tck_s1_reg;
         tck_s3_reg   <= tck_s2_reg;
         tms_s1_reg   <= I_TEST_MODE_SELECT;
         tms_s2_reg   <= tms_s1_reg;
      end
   end

   // ------------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------------
   psb_burst_e            burst_reg;
   logic [BURST_LO_W-1:0] base_reg;
   logic [BURST_LO_W-1:0] cnt_reg;
   logic [HI_W-1:0]       hi_reg;
   logic                  buf_in_ready;

   // Sleep is reached two cycles after the request, through the synchroniser
   wire logic asleep   = sleep_s2_reg;
   wire logic live     = ~qual_n_reg & ~asleep;
   wire logic qual     = live & buf_in_ready;
   wire logic selected = ~sel_first_n_reg & sel_second_reg & ~sel_third_n_reg;
   wire logic load     = qual & ~adv_reg;
   wire logic start    = load & selected;
   wire logic desel    = load & ~selected;
   // Advance ignores selects and strobe; with no burst open it keeps deselect
   wire logic advance  = qual & adv_reg & (burst_reg != PSB_IDLE);
   wire logic beat_rd  = (start & write_n_reg) |
                         (advance & (burst_reg == PSB_READ));
   wire logic beat_wr  = (start & ~write_n_reg) |
                         (advance & (burst_reg == PSB_WRITE));

   // ------------------------------------------------------------------
   // Beat address
   // ------------------------------------------------------------------
   logic [BURST_LO_W-1:0] beat_lo;
   wire logic [BURST_LO_W-1:0] cnt_next = cnt_reg + BURST_STEP;
   wire logic [BURST_LO_W-1:0] use_base = start ? addr_reg[BURST_LO_W-1:0] : base_reg;
   wire logic [BURST_LO_W-1:0] use_beat = start ? BURST_CNT_RST : cnt_next;
   wire logic [HI_W-1:0]       use_hi   = start ? addr_reg[ADDR_W-1:BURST_LO_W] : hi_reg;
   wire logic [ADDR_W-1:0]     beat_addr = {use_hi, beat_lo};

   psb_burst_seq u_seq (
      .i_base       (use_base),
      .i_beat       (use_beat),
      .i_interleave (order_s2_reg),
      .o_lo         (beat_lo)
   );

   // Burst state moves only on a qualified edge
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         burst_reg <= PSB_IDLE;
         cnt_reg   <= BURST_CNT_RST;
      end else if (start) begin
         burst_reg <= write_n_reg ? PSB_READ : PSB_WRITE;
         cnt_reg   <= BURST_CNT_RST;
      end else if (desel) begin
         burst_reg <= PSB_IDLE;
      end else if (advance) begin
         cnt_reg   <= cnt_next;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (start) begin
         base_reg <= addr_reg[BURST_LO_W-1:0];
         hi_reg   <= addr_reg[ADDR_W-1:BURST_LO_W];
      end
   end

   // ------------------------------------------------------------------
   // Storage array and write pipeline
   // ------------------------------------------------------------------
   logic              wr1_v_reg;
   logic              wr2_v_reg;
   logic [ADDR_W-1:0] wr1_addr_reg;
   logic [ADDR_W-1:0] wr2_addr_reg;
   logic [LANES-1:0]  wr1_lane_n_reg;
   logic [LANES-1:0]  wr2_lane_n_reg;

   // Data phase lands two qualified edges after the beat
   wire logic wr_fire = qual & wr2_v_reg;
   wire logic [DATA_W-1:0] rd_word;                                     // Filled per lane below

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         wr1_v_reg <= 1'b0;
         wr2_v_reg <= 1'b0;
      end else if (qual) begin
         wr1_v_reg <= beat_wr;
         wr2_v_reg <= wr1_v_reg;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (qual) begin
         wr1_addr_reg   <= beat_addr;
         wr1_lane_n_reg <= lane_n_reg;
         wr2_addr_reg   <= wr1_addr_reg;
         wr2_lane_n_reg <= wr1_lane_n_reg;
      end
   end

   // One array per byte lane, so each array has a single writer
   // A read of a word still in the write pipe returns the old contents
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] mem_lane [0:(2**ADDR_W)-1];
      assign rd_word[g*LANE_W +: LANE_W] = mem_lane[beat_addr];
      always_ff @(posedge I_CORE_CLK) begin
         if (wr_fire && !wr2_lane_n_reg[g]) begin
            mem_lane[wr2_addr_reg] <= dq_in_reg[g*LANE_W +: LANE_W];
         end
      end
   end

   // ------------------------------------------------------------------
   // Read path: buffer then output registers
   // ------------------------------------------------------------------
   logic              buf_out_valid;
   logic [DATA_W:0]   buf_out_data;
   // Writes and deselects carry a release word, so pins float for them
   wire logic         drive_word = beat_rd & ~oe_n_s2_reg;
   wire logic         pop        = buf_out_valid & ~qual_n_reg;

   psb_pair_buf #(
      .WIDTH (DATA_W + 1)
   ) u_buf (
      .i_clk       (I_CORE_CLK),
      .i_rst_n     (I_RST_N),
      .i_in_valid  (live),
      .o_in_ready  (buf_in_ready),
      .i_in_data   ({drive_word, rd_word}),
      .o_out_valid (buf_out_valid),
      .i_out_ready (~qual_n_reg),
      .o_out_data  (buf_out_data)
   );

   // Output enable going high releases the pins even in a stretched cycle
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         O_DQ_OE <= DRIVE_RST;
      end else if (asleep) begin
         O_DQ_OE <= 1'b0;
      end else if (pop) begin
         O_DQ_OE <= buf_out_data[DATA_W];
      end else begin
         O_DQ_OE <= O_DQ_OE & ~oe_n_s2_reg;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         O_DQ <= '0;
      end else if (pop) begin
         O_DQ <= buf_out_data[DATA_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // Sleep flag and test port sampling
   // ------------------------------------------------------------------
   wire logic tck_rise = tck_s2_reg & ~tck_s3_reg;

   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         O_SLEEP_ACTIVE     <= 1'b0;
         O_TEST_MODE_SAMPLE <= TEST_SAMPLE_RST;
      end else begin
         O_SLEEP_ACTIVE <= asleep;
         if (tck_rise) begin
            O_TEST_MODE_SAMPLE <= tms_s2_reg;
         end
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);

   a_hold_unqualified: assert property (
      (qual_n_reg && burst_reg != PSB_IDLE) |=> $stable(burst_reg) && $stable(cnt_reg)
   ) else $error("burst state moved on an unqualified edge");

   a_read_drive: assert property (
      beat_rd && !oe_n_s2_reg && !asleep |=> O_DQ_OE && (O_DQ == $past(rd_word))
   ) else $error("read data not driven after the next edge");

   a_write_float: assert property (
      beat_wr |=> !O_DQ_OE
   ) else $error("pins driven during a write");

   a_desel_float: assert property (
      desel |=> !O_DQ_OE ##1 (!O_DQ_OE || $past(beat_rd))
   ) else $error("pins driven after deselect");

   a_write_commit: assert property (
      beat_wr ##1 qual ##1 qual |-> wr_fire
   ) else $error("write data not latched two edges after start");

   a_type_kept: assert property (
      advance |=> burst_reg == $past(burst_reg)
   ) else $error("burst type changed during a burst");

   a_counter_step: assert property (
      advance |=> cnt_reg == BURST_LO_W'($past(cnt_reg) + BURST_STEP)
   ) else $error("burst counter did not step by one");

   a_linear_order: assert property (
      advance && !order_s2_reg |-> beat_lo == BURST_LO_W'(base_reg + cnt_next)
   ) else $error("linear order wrong");

   a_start_select: assert property (
      start |-> !sel_first_n_reg && sel_second_reg && !sel_third_n_reg && !adv_reg
   ) else $error("access started without all selects active");

   a_sleep_float: assert property (
      sleep_s2_reg [*2] |-> !O_DQ_OE
   ) else $error("pins driven while asleep");

   c_read_burst: cover property (start && write_n_reg ##1 advance ##1 advance ##1 advance);
   c_write_then_read: cover property (beat_wr ##1 beat_rd);
   c_stretch: cover property (beat_rd ##1 qual_n_reg [*2] ##1 pop);
   c_sleep: cover property (!asleep ##1 asleep ##[1:20] !asleep);

endmodule : psb_sram_top

//--- inc/psb_pkg.sv
// Shared constants and types of the pipelined burst SRAM access block
package psb_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int unsigned CORE_PERIOD_PS   = 8000;  // 125 MHz core clock
   localparam int unsigned CLK_TO_OUT_PS    = 2600;  // Clock to output delay, fastest grade
   // Longest time rounds down, never below one cycle
   localparam int unsigned CLK_TO_OUT_CYC   =
      (CLK_TO_OUT_PS / CORE_PERIOD_PS) > 0 ? (CLK_TO_OUT_PS / CORE_PERIOD_PS) : 1;
   localparam int unsigned SLEEP_ENTRY_CYC  = 2;     // Cycles to enter or leave sleep

   // ------------------------------------------------------------------
   // Burst counter layout and reset values
   // ------------------------------------------------------------------
   localparam int unsigned BURST_LO_W       = 2;     // Counter covers the two lowest bits
   localparam logic [1:0]  BURST_CNT_RST    = 2'h0;
   localparam logic [1:0]  BURST_STEP       = 2'h1;
   localparam logic [1:0]  BUF_CNT_RST      = 2'h0;
   localparam logic [1:0]  BUF_CNT_FULL     = 2'h2;
   localparam logic        DRIVE_RST        = 1'b0;  // Data pins released after reset
   localparam logic        QUAL_N_RST       = 1'b1;  // Qualifier sampled inactive at reset
   localparam logic        TEST_SAMPLE_RST  = 1'b1;

   // ------------------------------------------------------------------
   // Burst type held for the whole burst
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      PSB_IDLE  = 2'b00,
      PSB_READ  = 2'b01,
      PSB_WRITE = 2'b10
   } psb_burst_e;

endpackage : psb_pkg

//--- verification/pipelined_burst_sram_access_bench.sv
// Self-checking bench of the pipelined burst SRAM access block
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module pipelined_burst_sram_access_bench
   import psb_pkg::*;
;
   // ------------------------------------------------
   // Pins and rows
   // ------------------------------------------------
   typedef struct packed {
      logic q; logic [2:0] cs; logic adv; logic wn; logic [3:0] bw; logic [5:0] a;
      logic [2:0] di; logic s; logic o; logic z; logic [2:0] dx;
   } psb_row_s;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        tck = 1'b0;
   logic        tms = 1'b1;
   logic        qn, adv, wn, order, oe_n, slp, dq_oe, slp_act, tm_smp;
   logic [2:0]  sel;
   logic [3:0]  bw;
   logic [5:0]  a;
   logic [35:0] dq_in, dq_out;
   logic [35:0] dv [0:7];
   int          bad_count = 0;
   int          tests_run = 0;
   // Write burst with a frozen edge, byte write, linear then interleaved reads
   psb_row_s rows [0:28] = '{
      '{0,2,0,0,0,5,0,0,0,0,0}, '{0,7,1,1,0,0,0,0,0,0,0}, '{1,7,1,1,0,0,1,0,0,0,0},
      '{0,7,1,1,0,0,1,0,0,0,0}, '{0,7,1,1,0,0,2,0,0,0,0}, '{0,7,0,1,0,0,3,0,0,0,0},
      '{0,7,0,1,0,0,4,0,0,0,0}, '{0,2,0,0,6,5,0,0,0,0,0}, '{0,7,0,1,15,0,0,0,0,0,0},
      '{0,7,0,1,15,0,5,0,0,0,0}, '{0,7,0,1,15,0,0,0,0,0,0}, '{0,2,0,1,15,5,0,0,0,0,0},
      '{0,7,1,0,0,0,0,0,0,0,0}, '{0,7,1,0,0,0,0,0,0,0,6}, '{0,7,1,0,0,0,0,0,0,0,2},
      '{0,7,0,1,15,0,0,0,0,0,3}, '{0,7,0,1,15,0,0,0,0,0,4}, '{0,7,0,1,15,0,0,0,0,0,0},
      '{0,7,0,1,15,0,0,1,0,0,0}, '{0,7,0,1,15,0,0,1,0,0,0}, '{0,7,0,1,15,0,0,1,0,0,0},
      '{0,2,0,1,15,5,0,1,0,0,0}, '{0,7,1,0,0,0,0,1,0,0,0}, '{0,7,1,0,0,0,0,1,0,0,6},
      '{0,7,1,0,0,0,0,1,0,0,4}, '{0,7,0,1,15,0,0,1,0,0,3}, '{0,7,0,1,15,0,0,1,0,0,2},
      '{0,7,0,1,15,0,0,1,0,0,0}, '{0,7,0,1,15,0,0,1,0,0,0}};

   // Core clock, 8 ns period
   always #4 clk = ~clk;

   psb_ctrl_model ctrl (.o_qual_n(qn), .o_sel(sel), .o_adv(adv), .o_write_n(wn),
      .o_lane_n(bw), .o_addr(a), .o_dq(dq_in), .o_order(order), .o_oe_n(oe_n),
      .o_sleep(slp));
   psb_sram_top #(.ADDR_W(6)) uut (.I_CORE_CLK(clk), .I_RST_N(rst_n),
      .I_CLOCK_QUALIFY_N(qn), .I_SELECT_FIRST_N(sel[2]), .I_SELECT_SECOND(sel[1]),
      .I_SELECT_THIRD_N(sel[0]), .I_ADVANCE_OR_LOAD(adv), .I_WRITE_N(wn),
      .I_BYTE_LANE_WRITE_N(bw), .I_ADDR(a), .I_DQ(dq_in), .I_OUTPUT_EN_N(oe_n),
      .I_BURST_ORDER(order), .I_SLEEP_REQUEST(slp), .I_TEST_CLOCK(tck),
      .I_TEST_MODE_SELECT(tms), .O_DQ(dq_out), .O_DQ_OE(dq_oe),
      .O_SLEEP_ACTIVE(slp_act), .O_TEST_MODE_SAMPLE(tm_smp));

   // ------------------------------------------------
   // Tasks
   // ------------------------------------------------
   // Outputs of the last edge are checked before the next command goes out
   task automatic run(input psb_row_s r);
      @(negedge clk);
      `CHK("oe", r.dx != 3'h0, dq_oe)
      if (r.dx != 3'h0)
         `CHK("dq", dv[r.dx], dq_out)
      ctrl.put(r.q, r.cs, r.adv, r.wn, r.bw, r.a, dv[r.di], r.di != 3'h0, r.s, r.o, r.z);
   endtask : run

   // Slow test clock, two pulses, well below the core rate
   task automatic tpulse(input logic v);
      tms = v;
      repeat (4) begin
         repeat (4) @(negedge clk);
         tck = ~tck;
      end
      repeat (6) @(negedge clk);
      `CHK("tms", v, tm_smp)
   endtask : tpulse

   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_sim

   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial begin
      dv = '{36'h0, 36'h1_2345_6789, 36'h9_8765_4321, 36'hA_5A5A_5A5A,
             36'h5_A5A5_A5A5, 36'hF_0F0F_0F0F, 36'h0, 36'h0};
      // Only lanes 0 and 3 of the byte write land on the first word
      dv[6] = {dv[5][35:27], dv[1][26:9], dv[5][8:0]};
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      // Each row's expectation belongs to the command put two rows earlier
      foreach (rows[i])
         run(rows[i]);
      // Output enable high: a read must leave the pins released
      repeat (3) run('{0,7,0,1,15,0,0,1,1,0,0});
      run('{0,2,0,1,15,5,0,1,1,0,0});
      repeat (4) run('{0,7,0,1,15,0,0,1,1,0,0});
      // Sleep after deselect; a read while asleep is ignored
      repeat (5) run('{0,7,0,1,15,0,0,1,0,1,0});
      `CHK("sleep", 1'b1, slp_act)
      run('{0,2,0,1,15,5,0,1,0,1,0});
      repeat (4) run('{0,7,0,1,15,0,0,1,0,1,0});
      repeat (5) run('{0,7,0,1,15,0,0,1,0,0,0});
      `CHK("sleep", 1'b0, slp_act)
      run('{0,2,0,1,15,5,0,1,0,0,0});
      run('{0,7,0,1,15,0,0,1,0,0,0});
      run('{0,7,0,1,15,0,0,1,0,0,6});
      tpulse(1'b0);
      tpulse(1'b1);
      tpulse(1'b0);
      // Reset in mid-run restores the idle outputs
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      `CHK("rst oe", 1'b0, dq_oe)
      `CHK("rst dq", 36'h0, dq_out)
      `CHK("rst tms", 1'b1, tm_smp)
      // Read right after release, then two frozen edges while output enable rises
      rst_n = 1'b1;
      run('{0,2,0,1,15,5,0,1,0,0,0});
      run('{1,7,0,1,15,0,0,1,1,0,0});
      run('{1,7,0,1,15,0,0,1,1,0,6});
      run('{0,7,0,1,15,0,0,1,1,0,6});
      run('{0,7,0,1,15,0,0,1,1,0,0});
      end_sim();
   end

   // Watchdog, far beyond the 135 or so cycles the sequence needs
   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      end_sim();
   end
endmodule : pipelined_burst_sram_access_bench

//--- verification/psb_ctrl_model.sv
// Memory controller model that drives the command and data pins
`timescale 1ns/100ps
module psb_ctrl_model
   import psb_pkg::*;
(
   output      logic        o_qual_n,
   output      logic [2:0]  o_sel,
   output      logic        o_adv,
   output      logic        o_write_n,
   output      logic [3:0]  o_lane_n,
   output      logic [5:0]  o_addr,
   output      logic [35:0] o_dq,
   output      logic        o_order,
   output      logic        o_oe_n,
   output      logic        o_sleep
);
   // Idle and deselected from time zero
   initial put(1'b0, 3'h7, 1'b0, 1'b1, 4'hF, 6'h00, 36'h0, 1'b1, 1'b0, 1'b0, 1'b0);

   // One command cycle, entered just after a falling edge
   task automatic put(input logic q, input logic [2:0] cs, input logic adv,
                      input logic wn, input logic [3:0] bw, input logic [5:0] a,
                      input logic [35:0] d, input logic dv, input logic s,
                      input logic oe, input logic z);
      o_qual_n  = q;
      o_sel     = cs;
      o_adv     = adv;
      o_write_n = wn;
      o_lane_n  = bw;
      o_addr    = a;
      // Outside its data phase the bus wobbles, so no stale word can pass
      o_dq      = dv ? d : ~o_dq;
      o_order   = s;
      o_oe_n    = oe;
      o_sleep   = z;
   endtask : put
endmodule : psb_ctrl_model
